// ---- design/link_cfg_pkg.sv ----
// Shared constants and types for the link general configuration bank.
// Assumes a 10 MHz core clock and a byte-wide local register port.
package link_cfg_pkg;

  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_GEN_CFG_ONE = 8'h03;
  localparam logic [7:0] OFS_WDOG = 8'h04;
  localparam logic [7:0] OFS_I2C_CTL_ONE = 8'h05;
  localparam logic [7:0] RST_GEN_CFG_ONE = 8'hf0;
  localparam logic [7:0] RST_WDOG = 8'hfe;
  localparam logic [7:0] RST_I2C_CTL_ONE = 8'h1e;
  // Bit 0 of the first configuration register is read-only zero.
  localparam logic [7:0] GEN_CFG_ONE_WMASK = 8'hfe;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_CHECK_GEN = 6;
  localparam int BIT_PULL_DIR = 5;
  localparam int BIT_SYNC_FILT = 4;
  localparam int BIT_PASS_MATCH = 3;
  localparam int BIT_AUTO_ACK = 2;
  localparam int BIT_COLOUR_GATE = 1;
  localparam int BIT_WDOG_OFF = 0;
  localparam int WDOG_TMO_LSB = 1;
  localparam int BIT_PASS_ALL = 7;
  localparam int SDA_HOLD_LSB = 4;
  localparam int GLITCH_LSB = 0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int WDOG_UNIT_MS = 2;
  localparam int WDOG_UNIT_CYCLES = WDOG_UNIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SDA_HOLD_STEP_NS = 50;
  localparam int GLITCH_STEP_NS = 5;
  localparam int SYNC_FILT_SINGLE = 2;
  localparam int HS_FILT_DUAL = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic display_enable;
    logic horiz_sync;
    logic vert_sync;
  } sync_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic {WD_IDLE, WD_BUSY} wdog_state_t;

endpackage : link_cfg_pkg

// ---- design/link_general_config_regs.sv ----
// General configuration bank of a serial-video deserializer: three byte
// registers, sync glitch filters, colour gating, forwarding decisions and
// the control-channel watchdog.
// Assumes the local I2C target decodes bus cycles into one-cycle register
// strobes on req; all inputs are synchronous to clk.
//
// Behaviour
// - Bit 6 of register one enables the check generator; reset on.
// - Bit 5 of register one picks pull-down at one, pull-up at zero.
// - With filtering on, sync and enable pulses under two clocks drop.
// - The horizontal-sync filter is two clocks, or four on two links.
// - The matched bit forwards a transaction whose decode hits.
// - The auto-acknowledge bit acks writes regardless of forward lock.
// - With a protecting serializer, colour is always gated by enable.
// - Otherwise colour passes ungated unless the gating bit is set.
// - A control transaction not done in the timeout (2 ms units) ends.
// - Watchdog bit 0 disables the watchdog when one; it resets to zero.
// - Bit 7 of the I2C control register forwards every transaction.
// - Bits 6 to 4 set the data-line hold time in 50 ns steps, reset one.
// - Bits 3 to 0 set the glitch reject width in 5 ns steps, reset 0xe.
// - Back channel stops only if enable and both forward bits are low.
`timescale 1ns/1ps
module link_general_config_regs
  import link_cfg_pkg::*;
#(
  parameter int PIX_W = 24,
  parameter int UNIT_CYCLES = WDOG_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Local register port
  input reg_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  // Video path
  input wire logic dual_link,
  input wire logic serializer_protected,
  input sync_t sync_in,
  input wire logic [PIX_W-1:0] pix_in,
  output sync_t sync_out,
  output logic [PIX_W-1:0] pix_out,
  // Control channel
  input wire logic addr_match,
  input wire logic fwd_locked,
  input wire logic write_req,
  input wire logic back_channel_on,
  input wire logic txn_start,
  input wire logic txn_done,
  output logic i2c_fwd_req,
  output logic write_ack,
  output logic back_channel_active,
  output logic txn_timeout,
  // Static configuration
  output logic back_channel_check_gen_on,
  output logic idle_input_pull_dir,
  output logic [2:0] sda_hold_steps,
  output logic [3:0] glitch_steps
);

  // Every check below samples on the rising clock edge outside reset.
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] gen_reg, gen_next;
  logic [7:0] wdog_reg, wdog_next;
  logic [7:0] ictl_reg, ictl_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;

  // Writes update the addressed byte; reads return it next cycle.
  always_comb begin
    gen_next = gen_reg;
    wdog_next = wdog_reg;
    ictl_next = ictl_reg;
    rdata_next = rdata_reg;
    rvalid_next = req.rd;
    if (req.wr) begin
      unique case (req.addr)
        OFS_GEN_CFG_ONE: gen_next = req.wdata & GEN_CFG_ONE_WMASK;
        OFS_WDOG: wdog_next = req.wdata;
        OFS_I2C_CTL_ONE: ictl_next = req.wdata;
        default: ;
      endcase
    end
    if (req.rd) begin
      unique case (req.addr)
        OFS_GEN_CFG_ONE: rdata_next = gen_reg & GEN_CFG_ONE_WMASK;
        OFS_WDOG: rdata_next = wdog_reg;
        OFS_I2C_CTL_ONE: rdata_next = ictl_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Register stage for the configuration bytes.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gen_reg <= RST_GEN_CFG_ONE;
      wdog_reg <= RST_WDOG;
      ictl_reg <= RST_I2C_CTL_ONE;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      gen_reg <= gen_next;
      wdog_reg <= wdog_next;
      ictl_reg <= ictl_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign rdata = rdata_reg;
  assign rvalid = rvalid_reg;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  logic filt_on, pass_match, pass_all, auto_ack, colour_gated_by_valid;
  logic ctrl_channel_timeout_off;
  logic [6:0] ctrl_channel_timeout;

  // Static fields drive the block and its configuration outputs.
  assign back_channel_check_gen_on = gen_reg[BIT_CHECK_GEN];
  assign idle_input_pull_dir = gen_reg[BIT_PULL_DIR];
  assign filt_on = gen_reg[BIT_SYNC_FILT];
  assign pass_match = gen_reg[BIT_PASS_MATCH];
  assign auto_ack = gen_reg[BIT_AUTO_ACK];
  assign colour_gated_by_valid = gen_reg[BIT_COLOUR_GATE];
  assign ctrl_channel_timeout = wdog_reg[WDOG_TMO_LSB +: 7];
  assign ctrl_channel_timeout_off = wdog_reg[BIT_WDOG_OFF];
  assign pass_all = ictl_reg[BIT_PASS_ALL];
  assign sda_hold_steps = ictl_reg[SDA_HOLD_LSB +: 3];
  assign glitch_steps = ictl_reg[GLITCH_LSB +: 4];

  // ----------------------------------------------------------------
  // Forwarding, acknowledge and back channel
  // ----------------------------------------------------------------
  // Handshake decisions are combinational from live fields.
  assign i2c_fwd_req = pass_all | (pass_match & addr_match);
  assign write_ack = write_req & (auto_ack | fwd_locked);
  assign back_channel_active = back_channel_on | pass_match | pass_all;

  // ----------------------------------------------------------------
  // Sync glitch filters
  // ----------------------------------------------------------------
  sync_t sync_reg, sync_next;
  logic [2:0][2:0] cnt_reg, cnt_next;
  logic [2:0] raw, held;

  assign raw = sync_in;
  assign held = sync_reg;

  // With filtering on, a level is accepted only after it stands for the full filter width.
  always_comb begin
    logic [2:0] width;
    logic [2:0] nxt;
    width = 3'd0;
    nxt = held;
    cnt_next = cnt_reg;
    for (int i = 0; i < 3; i++) begin
      // Index 1 is the horizontal sync.
      width = (i == 1 && dual_link) ? 3'(HS_FILT_DUAL)
                                    : 3'(SYNC_FILT_SINGLE);
      if (!filt_on) begin
        nxt[i] = raw[i];
        cnt_next[i] = 3'd0;
      end else if (raw[i] == held[i]) begin
        cnt_next[i] = 3'd0;
      end else if (cnt_reg[i] + 3'd1 >= width) begin
        nxt[i] = raw[i];
        cnt_next[i] = 3'd0;
      end else begin
        cnt_next[i] = cnt_reg[i] + 3'd1;
      end
    end
    sync_next = nxt;
  end

  // Register stage for the filters.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_reg <= '0;
      cnt_reg <= '0;
    end else begin
      sync_reg <= sync_next;
      cnt_reg <= cnt_next;
    end
  end

  assign sync_out = sync_reg;

  // ----------------------------------------------------------------
  // Colour gating
  // ----------------------------------------------------------------
  logic [PIX_W-1:0] pix_reg, pix_next;
  logic gate;

  // A protecting serializer forces gating; otherwise the bit decides.
  assign gate = serializer_protected | colour_gated_by_valid;

  always_comb begin
    pix_next = (gate && !sync_in.display_enable) ? '0 : pix_in;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pix_reg <= '0;
    end else begin
      pix_reg <= pix_next;
    end
  end

  assign pix_out = pix_reg;

  // ----------------------------------------------------------------
  // Control-channel watchdog
  // ----------------------------------------------------------------
  wdog_state_t wd_reg, wd_next;
  logic [$clog2(UNIT_CYCLES)-1:0] tick_reg, tick_next;
  logic [6:0] unit_reg, unit_next;
  logic tmo_reg, tmo_next;

  // Count whole units while a transaction is open; a zero field wraps
  // and expires only after 128 units, so software must avoid it.
  always_comb begin
    wd_next = wd_reg;
    tick_next = tick_reg;
    unit_next = unit_reg;
    tmo_next = 1'b0;
    unique case (wd_reg)
      WD_IDLE: begin
        if (txn_start) begin
          wd_next = WD_BUSY;
          tick_next = '0;
          unit_next = 7'd0;
        end
      end
      WD_BUSY: begin
        if (txn_done) begin
          wd_next = WD_IDLE;
        end else if (!ctrl_channel_timeout_off) begin
          if (tick_reg == ($clog2(UNIT_CYCLES))'(UNIT_CYCLES - 1)) begin
            tick_next = '0;
            unit_next = unit_reg + 7'd1;
            if (unit_reg + 7'd1 == ctrl_channel_timeout) begin
              tmo_next = 1'b1;
              wd_next = WD_IDLE;
            end
          end else begin
            tick_next = tick_reg + 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_reg <= WD_IDLE;
      tick_reg <= '0;
      unit_reg <= 7'd0;
      tmo_reg <= 1'b0;
    end else begin
      wd_reg <= wd_next;
      tick_reg <= tick_next;
      unit_reg <= unit_next;
      tmo_reg <= tmo_next;
    end
  end

  assign txn_timeout = tmo_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_check_gen_write: assert property (
    req.wr && req.addr == OFS_GEN_CFG_ONE |=>
      back_channel_check_gen_on == $past(req.wdata[BIT_CHECK_GEN]))
    else $error("check generator enable did not follow write");

  a_pull_dir_write: assert property (
    req.wr && req.addr == OFS_GEN_CFG_ONE |=>
      idle_input_pull_dir == $past(req.wdata[BIT_PULL_DIR]))
    else $error("pull direction did not follow write");

  a_de_short_drop: assert property (
    filt_on && $changed(sync_out.display_enable) |->
      $past(sync_in.display_enable, 1) == sync_out.display_enable &&
      $past(sync_in.display_enable, 2) == sync_out.display_enable)
    else $error("display enable changed on a short pulse");

  a_filter_bypass: assert property (
    arst_n && !filt_on |=> sync_out.vert_sync == $past(sync_in.vert_sync))
    else $error("unfiltered vertical sync not passed");

  a_hs_dual_width: assert property (
    filt_on && dual_link && $past(dual_link, 4) && $past(filt_on, 4) &&
      $changed(sync_out.horiz_sync) |->
      $past(sync_in.horiz_sync, 4) == sync_out.horiz_sync &&
      $past(sync_in.horiz_sync, 3) == sync_out.horiz_sync)
    else $error("horizontal sync passed under four clocks");

  a_fwd_decide: assert property (
    i2c_fwd_req |-> pass_all || (pass_match && addr_match))
    else $error("forward without enabling bit");

  a_auto_ack: assert property (
    write_req && auto_ack && !fwd_locked |-> write_ack)
    else $error("write not acknowledged under auto acknowledge");

  a_prot_gating: assert property (
    serializer_protected && !sync_in.display_enable |=> pix_out == '0)
    else $error("colour leaked outside display enable");

  a_plain_pass: assert property (
    arst_n && !serializer_protected && !colour_gated_by_valid |=>
      pix_out == $past(pix_in))
    else $error("ungated colour altered");

  a_wdog_disabled: assert property (
    txn_timeout |-> !$past(ctrl_channel_timeout_off) &&
      $past(unit_reg) + 7'd1 == $past(ctrl_channel_timeout))
    else $error("timeout at wrong count or while disabled");

  a_back_channel: assert property (
    !back_channel_on && !pass_match && !pass_all |-> !back_channel_active)
    else $error("back channel kept on");

  a_reserved_zero: assert property (
    req.rd && req.addr == OFS_GEN_CFG_ONE |=> rvalid && rdata[0] == 1'b0)
    else $error("reserved bit read nonzero");

endmodule : link_general_config_regs

// ---- verification/ctrl_peer_model.sv ----
// Behavioural far-side peer of the control channel: it opens a
// transaction on request and closes it late, or never.
// Assumes go is a one-cycle pulse driven just after a rising edge.
`timescale 1ns/1ps
module ctrl_peer_model (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Scenario control, hold zero means the peer never answers
  input wire logic go,
  input wire logic [7:0] hold,
  // Transaction strobes
  output logic txn_start,
  output logic txn_done
);
  logic [7:0] cnt_reg;

  // --------------------------------------------------------------
  // Transaction sequencing
  // --------------------------------------------------------------
  // Start follows go; done comes hold cycles later, so a slow peer
  // lets the watchdog expire.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txn_start <= 1'b0;
      txn_done <= 1'b0;
      cnt_reg <= 8'h00;
    end else begin
      txn_start <= go;
      txn_done <= (cnt_reg == 8'h01);
      if (go) begin
        cnt_reg <= hold;
      end else if (cnt_reg != 8'h00) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
endmodule : ctrl_peer_model

// ---- verification/test_link_general_config_regs.sv ----
// Self-checking bench of the general configuration bank.
// Assumes the strobe register port and a watchdog unit of 4 cycles.
`timescale 1ns/1ps
module test_link_general_config_regs;
  import link_cfg_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  reg_req_t req = '0;
  sync_t sync_in = '0;
  sync_t sync_out;
  logic [23:0] pix_in = 24'h5a5a5a;
  logic [23:0] pix_out;
  logic [7:0] rdata, hold = 8'h00;
  logic rvalid, txn_start, txn_done, i2c_fwd_req, write_ack, bc_act;
  logic txn_timeout, check_gen, pull_dir, go = 1'b0, prot = 1'b0;
  logic dual_link = 1'b0, addr_match = 1'b0, fwd_locked = 1'b0;
  logic write_req = 1'b0, back_channel_on = 1'b0, seen;
  logic [2:0] sda_hold_steps;
  logic [3:0] glitch_steps;
  logic [7:0] n;
  int failures = 0;
  int n_compared = 0;

  // Clock of 100 ns period.
  always #50 clk = ~clk;

  link_general_config_regs #(.PIX_W(24), .UNIT_CYCLES(4)) dut_u (
    .clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata),
    .rvalid(rvalid), .dual_link(dual_link),
    .serializer_protected(prot), .sync_in(sync_in), .pix_in(pix_in),
    .sync_out(sync_out), .pix_out(pix_out), .addr_match(addr_match),
    .fwd_locked(fwd_locked), .write_req(write_req),
    .back_channel_on(back_channel_on), .txn_start(txn_start),
    .txn_done(txn_done), .i2c_fwd_req(i2c_fwd_req),
    .write_ack(write_ack), .back_channel_active(bc_act),
    .txn_timeout(txn_timeout), .back_channel_check_gen_on(check_gen),
    .idle_input_pull_dir(pull_dir), .sda_hold_steps(sda_hold_steps),
    .glitch_steps(glitch_steps));

  ctrl_peer_model peer_u (.clk(clk), .arst_n(arst_n), .go(go),
    .hold(hold), .txn_start(txn_start), .txn_done(txn_done));

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic chk(input string nm, input logic [23:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic conclude;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
  endtask : wr

  // The read answer stands for one cycle right after the taking edge.
  task automatic rd(input logic [7:0] a, exp);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req <= '0;
    #1;
    chk("rvalid", rvalid, 1'b1);
    chk("rdata", rdata, exp);
  endtask : rd

  // Drives a high pulse of len cycles on one sync line and watches.
  task automatic pulse(input int i, input int len, output logic s);
    s = 1'b0;
    @(posedge clk);
    sync_in[i] <= 1'b1;
    for (int k = 1; k < 10; k++) begin
      @(posedge clk);
      if (k == len) sync_in[i] <= 1'b0;
      #1;
      s = s | sync_out[i];
    end
  endtask : pulse

  // Counts cycles from the transaction start to the timeout pulse.
  task automatic wd_run(input logic [7:0] h, output logic [7:0] c);
    c = 8'h00;
    @(posedge clk);
    go <= 1'b1;
    hold <= h;
    @(posedge clk);
    go <= 1'b0;
    for (int k = 1; k < 40; k++) begin
      @(posedge clk);
      #1;
      if (txn_timeout === 1'b1 && c == 8'h00) c = k[7:0];
    end
  endtask : wd_run

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset;
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    rd(OFS_GEN_CFG_ONE, 8'hf0);
    rd(OFS_WDOG, 8'hfe);
    rd(OFS_I2C_CTL_ONE, 8'h1e);
    chk("check_gen", check_gen, 1'b1);
    chk("pull_dir", pull_dir, 1'b1);
    chk("sda_hold", sda_hold_steps, 3'h1);
    chk("glitch", glitch_steps, 4'he);
  endtask : t_reset

  task automatic t_regs;
    wr(OFS_GEN_CFG_ONE, 8'hff);
    rd(OFS_GEN_CFG_ONE, 8'hfe);
    wr(OFS_GEN_CFG_ONE, 8'h00);
    rd(OFS_GEN_CFG_ONE, 8'h00);
    chk("check_gen", check_gen, 1'b0);
    chk("pull_dir", pull_dir, 1'b0);
    wr(OFS_WDOG, 8'h55);
    rd(OFS_WDOG, 8'h55);
    wr(OFS_I2C_CTL_ONE, 8'ha5);
    rd(OFS_I2C_CTL_ONE, 8'ha5);
    chk("sda_hold", sda_hold_steps, 3'h2);
    chk("glitch", glitch_steps, 4'h5);
    wr(8'h07, 8'hff);
    rd(8'h07, 8'h00);
  endtask : t_regs

  task automatic t_forward;
    for (int m = 0; m < 4; m++) begin
      wr(OFS_GEN_CFG_ONE, {4'h0, m[0], 3'h0});
      wr(OFS_I2C_CTL_ONE, {m[1], 7'h1e});
      for (int a = 0; a < 2; a++) begin
        @(posedge clk);
        addr_match <= a[0];
        write_req <= 1'b1;
        fwd_locked <= a[0];
        back_channel_on <= a[0];
        #1;
        chk("fwd", i2c_fwd_req, m[1] | (m[0] & a[0]));
        chk("bc_act", bc_act, m[1] | m[0] | a[0]);
        chk("ack", write_ack, a[0]);
      end
    end
    wr(OFS_GEN_CFG_ONE, 8'h04);
    fwd_locked <= 1'b0;
    #1;
    chk("ack", write_ack, 1'b1);
  endtask : t_forward

  task automatic t_colour;
    for (int m = 0; m < 4; m++) begin
      wr(OFS_GEN_CFG_ONE, {6'h00, m[0], 1'b0});
      prot <= m[1];
      repeat (2) @(posedge clk);
      #1;
      chk("pix", pix_out, (m[0] | m[1]) ? 24'h0 : pix_in);
    end
    @(posedge clk);
    sync_in.display_enable <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("pix", pix_out, pix_in);
    @(posedge clk);
    sync_in.display_enable <= 1'b0;
  endtask : t_colour

  task automatic t_sync;
    pulse(2, 1, seen);
    chk("de1", seen, 1'b0);
    pulse(2, 2, seen);
    chk("de2", seen, 1'b1);
    pulse(1, 1, seen);
    chk("hs1", seen, 1'b0);
    pulse(0, 2, seen);
    chk("vs2", seen, 1'b1);
    @(posedge clk);
    dual_link <= 1'b1;
    pulse(1, 3, seen);
    chk("hs3", seen, 1'b0);
    pulse(1, 4, seen);
    chk("hs4", seen, 1'b1);
    pulse(2, 2, seen);
    chk("de2d", seen, 1'b1);
    wr(OFS_GEN_CFG_ONE, 8'he0);
    pulse(2, 1, seen);
    chk("de1off", seen, 1'b1);
  endtask : t_sync

  task automatic t_wdog;
    wr(OFS_WDOG, 8'h02);
    wd_run(8'h00, n);
    chk("tmo1", n, 8'h05);
    wd_run(8'h02, n);
    chk("done", n, 8'h00);
    wr(OFS_WDOG, 8'h04);
    wd_run(8'h00, n);
    chk("tmo2", n, 8'h09);
    wr(OFS_WDOG, 8'h03);
    wd_run(8'h00, n);
    chk("off", n, 8'h00);
  endtask : t_wdog

  // Main sequence, ending with a second reset in mid-run.
  initial begin
    t_reset();
    t_sync();
    t_regs();
    t_forward();
    t_colour();
    t_wdog();
    t_reset();
    conclude();
  end

  // Guard against a hang of the whole run.
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    conclude();
  end
endmodule : test_link_general_config_regs
